//--- src/pssu_unit.sv
`timescale 1ns/1ns
`default_nettype none
module pssu_unit
    import pssu_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic issue_valid,
    input wire logic [7:0] issue_escape,
    input wire logic [7:0] issue_opcode,
    input wire logic [7:0] issue_modrm,
    input wire logic [7:0] immediate_count_byte,
    input wire logic [2:0] issue_dest_index,
    input wire logic [63:0] dest_value,
    input wire logic [63:0] source_value,
    input wire logic source_is_memory,
    input wire logic protected_mode,
    input wire logic [1:0] current_privilege,
    input wire logic alignment_enabled,
    input wire logic mem_misaligned,
    input wire logic mem_addr_illegal,
    input wire logic mem_stack_segment,
    input wire logic mem_page_fault,
    input wire logic [31:0] mem_last_offset,
    input wire logic emulation_control_bit,
    input wire logic task_switched_bit,
    input wire logic math_pending,
    output logic result_write,
    output logic [2:0] result_index,
    output logic [63:0] result_value,
    output logic fault_valid,
    output pssu_fault_type fault_kind,
    output logic [15:0] fault_error_code,
    output logic [7:0] fault_vector,
    output logic flags_write
);
    // refused at elaboration: the lane slicing assumes a 64-bit register
    if (DATA_W != QUAD_W) begin : g_width_check
        $error("data width must be 64");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic legal;
    logic uses_imm;
    pssu_lane_type lane;
    pssu_kind_type kind;
    logic [63:0] count;
    logic [63:0] shifted;
    logic mem_src;
    pssu_fault_type next_fault;
    logic state_ok;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    pssu_decode u_decode (
        .escape(issue_escape),
        .opcode(issue_opcode),
        .modrm(issue_modrm),
        .legal(legal),
        .uses_imm(uses_imm),
        .lane(lane),
        .kind(kind)
    );

    // immediate zero-extended, never sign-extended
    assign count = uses_imm ? {56'h0, immediate_count_byte} : source_value;
    assign mem_src = source_is_memory && !uses_imm;

    pssu_shifter u_shifter (
        .operand(dest_value),
        .count(count),
        .lane(lane),
        .kind(kind),
        .result(shifted)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // priority: decode and machine-state faults before memory faults
    always_comb begin
        next_fault = PSSU_FAULT_NONE;
        if (!legal || emulation_control_bit) begin
            next_fault = PSSU_FAULT_INVALID_OPCODE;
        end else if (task_switched_bit) begin
            next_fault = PSSU_FAULT_DEVICE_NOT_AVAILABLE;
        end else if (math_pending) begin
            next_fault = PSSU_FAULT_MATH;
        end else if (mem_src && protected_mode) begin
            if (mem_addr_illegal) begin
                next_fault = mem_stack_segment ? PSSU_FAULT_STACK
                                               : PSSU_FAULT_GENERAL_PROTECTION;
            end else if (mem_page_fault) begin
                next_fault = PSSU_FAULT_PAGE;
            end else if (mem_misaligned && alignment_enabled
                         && current_privilege == CPL_USER) begin
                next_fault = PSSU_FAULT_ALIGNMENT_CHECK;
            end
        end else if (mem_src && mem_last_offset > REAL_LIMIT) begin
            next_fault = PSSU_FAULT_REAL_INT13;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (srst) begin
            result_write <= 1'b0;
        end else begin
            result_write <= issue_valid && next_fault == PSSU_FAULT_NONE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            result_index <= 3'h0;
            result_value <= 64'h0;
        end else if (issue_valid) begin
            result_index <= issue_dest_index;
            result_value <= shifted;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fault_valid <= 1'b0;
            fault_kind <= PSSU_FAULT_NONE;
            fault_error_code <= ERROR_CODE_ZERO;
            fault_vector <= 8'h00;
        end else begin
            fault_valid <= issue_valid && next_fault != PSSU_FAULT_NONE;
            fault_kind <= issue_valid ? next_fault : PSSU_FAULT_NONE;
            fault_error_code <= ERROR_CODE_ZERO;
            fault_vector <= (issue_valid && next_fault == PSSU_FAULT_REAL_INT13)
                            ? REAL_VECTOR : 8'h00;
        end
    end

    // shifts never touch arithmetic flags
    assign flags_write = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    a_write_no_fault: assert property (@(posedge clock) disable iff (srst)
        !(result_write && fault_valid)) else $error("write and fault together");

    a_write_follows: assert property (@(posedge clock) disable iff (srst)
        issue_valid && next_fault == PSSU_FAULT_NONE |=> result_write)
        else $error("clean issue not written");

    a_emul_fault: assert property (@(posedge clock) disable iff (srst)
        issue_valid && emulation_control_bit |=> fault_kind == PSSU_FAULT_INVALID_OPCODE)
        else $error("emulation bit did not fault");

    a_ts_fault: assert property (@(posedge clock) disable iff (srst)
        issue_valid && legal && !emulation_control_bit && task_switched_bit
        |=> fault_kind == PSSU_FAULT_DEVICE_NOT_AVAILABLE)
        else $error("task switched did not fault");

    a_align_user: assert property (@(posedge clock) disable iff (srst)
        fault_valid && fault_kind == PSSU_FAULT_ALIGNMENT_CHECK
        |-> $past(current_privilege) == CPL_USER)
        else $error("alignment fault outside user level");

    a_real_vector: assert property (@(posedge clock) disable iff (srst)
        fault_kind == PSSU_FAULT_REAL_INT13 |-> fault_vector == REAL_VECTOR
        && !$past(protected_mode)) else $error("real mode vector wrong");

    a_sll_overrange: assert property (@(posedge clock) disable iff (srst)
        issue_valid && kind == PSSU_KIND_SLL && count > QUAD_MAX
        |=> result_value == 64'h0) else $error("left over-range not zero");

    a_srl_overrange: assert property (@(posedge clock) disable iff (srst)
        issue_valid && kind == PSSU_KIND_SRL && count > QUAD_MAX
        |=> result_value == 64'h0) else $error("right over-range not zero");

    a_sra_sign: assert property (@(posedge clock) disable iff (srst)
        issue_valid && kind == PSSU_KIND_SRA && lane == PSSU_LANE_DWORD && count > DWORD_MAX
        |=> result_value[63:32] == {32{$past(dest_value[63])}}
        && result_value[31:0] == {32{$past(dest_value[31])}})
        else $error("arithmetic over-range not sign fill");

    a_imm_count: assert property (@(posedge clock) disable iff (srst)
        issue_valid && uses_imm |-> count[63:8] == 56'h0) else $error("immediate count wide");

    ////////////////////////////////////////////////////////////////////////////////
    // issues that no decode, emulation or task-switched fault stops; math_pending is not excluded
    assign state_ok = issue_valid && legal && !emulation_control_bit
                      && !task_switched_bit;

    a_idle_quiet: assert property (
        !issue_valid
        |=> !result_write && !fault_valid
        && fault_kind == PSSU_FAULT_NONE)
        else $error("output without issue");

    a_flags_still: assert property (!flags_write)
        else $error("flags written");

    a_code_zero: assert property (fault_error_code == ERROR_CODE_ZERO)
        else $error("error code not zero");

    a_escape_check: assert property (
        issue_valid && issue_escape != ESC_BYTE
        |=> fault_kind == PSSU_FAULT_INVALID_OPCODE)
        else $error("bad escape accepted");

    a_imm_form: assert property (
        issue_valid && uses_imm
        && issue_modrm[7:6] != MOD_REG
        |=> fault_kind == PSSU_FAULT_INVALID_OPCODE)
        else $error("memory immediate form accepted");

    a_math_fault: assert property (
        state_ok && math_pending
        |=> fault_kind == PSSU_FAULT_MATH)
        else $error("pending math not reported");

    a_addr_fault: assert property (
        state_ok && !math_pending && mem_src
        && protected_mode && mem_addr_illegal
        |=> fault_kind == ($past(mem_stack_segment)
        ? PSSU_FAULT_STACK : PSSU_FAULT_GENERAL_PROTECTION))
        else $error("address fault kind wrong");

    a_page_fault: assert property (
        state_ok && !math_pending && mem_src && protected_mode
        && !mem_addr_illegal && mem_page_fault
        |=> fault_kind == PSSU_FAULT_PAGE)
        else $error("page fault not reported");

    a_align_cause: assert property (
        fault_kind == PSSU_FAULT_ALIGNMENT_CHECK
        |-> $past(alignment_enabled) && $past(mem_misaligned)
        && $past(protected_mode))
        else $error("alignment fault without cause");

    a_real_limit: assert property (
        fault_kind == PSSU_FAULT_REAL_INT13
        |-> $past(mem_last_offset) > REAL_LIMIT)
        else $error("real fault inside limit");

    a_imm_no_mem: assert property (
        fault_kind inside {PSSU_FAULT_GENERAL_PROTECTION, PSSU_FAULT_STACK,
        PSSU_FAULT_PAGE, PSSU_FAULT_ALIGNMENT_CHECK}
        |-> !$past(uses_imm))
        else $error("memory fault on immediate count");

    a_index_echo: assert property (
        issue_valid |=> result_index == $past(issue_dest_index))
        else $error("destination index lost");

    a_zero_count: assert property (
        issue_valid && count == 64'h0
        |=> result_value == $past(dest_value))
        else $error("zero count changed value");

    a_sll_word_low: assert property (
        issue_valid && kind == PSSU_KIND_SLL && lane == PSSU_LANE_WORD
        && count != 64'h0
        |=> !result_value[0] && !result_value[16]
        && !result_value[32] && !result_value[48])
        else $error("word left shift low bit set");

    a_sll_word_over: assert property (
        issue_valid && kind == PSSU_KIND_SLL && lane == PSSU_LANE_WORD
        && count > WORD_MAX |=> result_value == 64'h0)
        else $error("word left over-range not zero");

    a_sra_word_keep: assert property (
        issue_valid && kind == PSSU_KIND_SRA && lane == PSSU_LANE_WORD
        |=> result_value[15] == $past(dest_value[15])
        && result_value[63] == $past(dest_value[63]))
        else $error("word sign bit lost");

    a_sra_word_fill: assert property (
        issue_valid && kind == PSSU_KIND_SRA && lane == PSSU_LANE_WORD
        && count > WORD_MAX
        |=> result_value[15:0] == {16{$past(dest_value[15])}}
        && result_value[63:48] == {16{$past(dest_value[63])}})
        else $error("word over-range not sign fill");

    a_srl_word_high: assert property (
        issue_valid && kind == PSSU_KIND_SRL && lane == PSSU_LANE_WORD
        && count != 64'h0
        |=> !result_value[15] && !result_value[31]
        && !result_value[47] && !result_value[63])
        else $error("word right shift high bit set");
endmodule
`default_nettype wire

//--- pkg/pssu_pkg.sv
package pssu_pkg;

    localparam int DATA_W = 64;
    localparam logic [7:0] ESC_BYTE = 8'h0f;

    localparam logic [7:0] OP_SLL_W = 8'hf1;
    localparam logic [7:0] OP_SLL_D = 8'hf2;
    localparam logic [7:0] OP_SLL_Q = 8'hf3;
    localparam logic [7:0] OP_SRA_W = 8'he1;
    localparam logic [7:0] OP_SRA_D = 8'he2;
    localparam logic [7:0] OP_SRL_W = 8'hd1;
    localparam logic [7:0] OP_SRL_D = 8'hd2;
    localparam logic [7:0] OP_SRL_Q = 8'hd3;
    localparam logic [7:0] OP_IMM_W = 8'h71;
    localparam logic [7:0] OP_IMM_D = 8'h72;
    localparam logic [7:0] OP_IMM_Q = 8'h73;

    localparam logic [2:0] REG_SLL = 3'h6;
    localparam logic [2:0] REG_SRA = 3'h4;
    localparam logic [2:0] REG_SRL = 3'h2;
    localparam logic [1:0] MOD_REG = 2'h3;

    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam int QUAD_W = 64;
    localparam logic [63:0] WORD_MAX = 64'h000000000000000f;
    localparam logic [63:0] DWORD_MAX = 64'h000000000000001f;
    localparam logic [63:0] QUAD_MAX = 64'h000000000000003f;

    localparam logic [1:0] CPL_USER = 2'h3;
    localparam logic [31:0] REAL_LIMIT = 32'h0000ffff;
    localparam logic [7:0] REAL_VECTOR = 8'h0d;
    localparam logic [15:0] ERROR_CODE_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        PSSU_LANE_WORD,
        PSSU_LANE_DWORD,
        PSSU_LANE_QUAD
    } pssu_lane_type;

    typedef enum logic [1:0] {
        PSSU_KIND_SLL,
        PSSU_KIND_SRA,
        PSSU_KIND_SRL
    } pssu_kind_type;

    typedef enum logic [3:0] {
        PSSU_FAULT_NONE,
        PSSU_FAULT_INVALID_OPCODE,
        PSSU_FAULT_DEVICE_NOT_AVAILABLE,
        PSSU_FAULT_MATH,
        PSSU_FAULT_GENERAL_PROTECTION,
        PSSU_FAULT_STACK,
        PSSU_FAULT_PAGE,
        PSSU_FAULT_ALIGNMENT_CHECK,
        PSSU_FAULT_REAL_INT13
    } pssu_fault_type;

endpackage

//--- src/pssu_decode.sv
`timescale 1ns/1ns
`default_nettype none
module pssu_decode
    import pssu_pkg::*;
(
    input wire logic [7:0] escape,
    input wire logic [7:0] opcode,
    input wire logic [7:0] modrm,
    output logic legal,
    output logic uses_imm,
    output pssu_lane_type lane,
    output pssu_kind_type kind
);
    logic [2:0] reg_field;
    assign reg_field = modrm[5:3];

    always_comb begin
        legal = escape == ESC_BYTE;
        uses_imm = 1'b0;
        lane = PSSU_LANE_WORD;
        kind = PSSU_KIND_SLL;
        case (opcode)
            OP_SLL_W: begin lane = PSSU_LANE_WORD; kind = PSSU_KIND_SLL; end
            OP_SLL_D: begin lane = PSSU_LANE_DWORD; kind = PSSU_KIND_SLL; end
            OP_SLL_Q: begin lane = PSSU_LANE_QUAD; kind = PSSU_KIND_SLL; end
            OP_SRA_W: begin lane = PSSU_LANE_WORD; kind = PSSU_KIND_SRA; end
            OP_SRA_D: begin lane = PSSU_LANE_DWORD; kind = PSSU_KIND_SRA; end
            OP_SRL_W: begin lane = PSSU_LANE_WORD; kind = PSSU_KIND_SRL; end
            OP_SRL_D: begin lane = PSSU_LANE_DWORD; kind = PSSU_KIND_SRL; end
            OP_SRL_Q: begin lane = PSSU_LANE_QUAD; kind = PSSU_KIND_SRL; end
            OP_IMM_W, OP_IMM_D, OP_IMM_Q: begin
                uses_imm = 1'b1;
                lane = opcode == OP_IMM_W ? PSSU_LANE_WORD :
                       opcode == OP_IMM_D ? PSSU_LANE_DWORD : PSSU_LANE_QUAD;
                // immediate forms need a register destination
                if (modrm[7:6] != MOD_REG) begin
                    legal = 1'b0;
                end
                case (reg_field)
                    REG_SLL: kind = PSSU_KIND_SLL;
                    REG_SRL: kind = PSSU_KIND_SRL;
                    REG_SRA: begin
                        kind = PSSU_KIND_SRA;
                        // no arithmetic quad shift exists
                        if (opcode == OP_IMM_Q) begin
                            legal = 1'b0;
                        end
                    end
                    default: legal = 1'b0;
                endcase
            end
            default: legal = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- src/pssu_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module pssu_shifter
    import pssu_pkg::*;
(
    input wire logic [63:0] operand,
    input wire logic [63:0] count,
    input wire pssu_lane_type lane,
    input wire pssu_kind_type kind,
    output logic [63:0] result
);
    // full 64-bit count compared, so 0x100 is never mistaken for 0
    function automatic logic [63:0] lane_shift(input logic [63:0] v, input logic [63:0] c,
                                               input pssu_kind_type k, input int w,
                                               input logic [63:0] max);
        logic [63:0] r;
        logic sign;
        logic [5:0] amt;
        r = '0;
        sign = v[w-1];
        amt = c[5:0];
        if (c > max) begin
            r = (k == PSSU_KIND_SRA && sign) ? '1 : '0;
        end else if (k == PSSU_KIND_SLL) begin
            r = v << amt;
        end else if (k == PSSU_KIND_SRA) begin
            r = v >> amt;
            for (int i = 0; i < 64; i++) begin
                if (i >= w - int'(amt) && sign) begin
                    r[i] = 1'b1;
                end
            end
        end else begin
            r = v >> amt;
        end
        for (int i = 0; i < 64; i++) begin
            if (i >= w) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction

    always_comb begin
        result = '0;
        case (lane)
            PSSU_LANE_WORD: begin
                for (int l = 0; l < DATA_W / WORD_W; l++) begin
                    result[l*WORD_W +: WORD_W] = 16'(lane_shift(
                        {48'h0, operand[l*WORD_W +: WORD_W]}, count, kind, WORD_W, WORD_MAX));
                end
            end
            PSSU_LANE_DWORD: begin
                for (int l = 0; l < DATA_W / DWORD_W; l++) begin
                    result[l*DWORD_W +: DWORD_W] = 32'(lane_shift(
                        {32'h0, operand[l*DWORD_W +: DWORD_W]}, count, kind, DWORD_W,
                        DWORD_MAX));
                end
            end
            default: result = lane_shift(operand, count, kind, QUAD_W, QUAD_MAX);
        endcase
    end
endmodule
`default_nettype wire

//--- verification/pssu_regfile_model.sv
`timescale 1ns/1ns
`default_nettype none
module pssu_regfile_model (
    input wire logic clock,
    input wire logic issue_valid,
    input wire logic [2:0] issue_dest_index,
    output logic [63:0] dest_value,
    input wire logic result_write,
    input wire logic [2:0] result_index,
    input wire logic [63:0] result_value,
    input wire logic load_en,
    input wire logic [2:0] load_index,
    input wire logic [63:0] load_value
);
    logic [63:0] regs [8];
    // outside an issue the read port shows junk, so a stale value never looks right
    // a result retiring at this edge is forwarded, as a bypassed register file would
    logic [63:0] read_word;
    assign read_word = (result_write && result_index == issue_dest_index) ? result_value
                                                                           : regs[issue_dest_index];
    assign dest_value = issue_valid ? read_word : ~read_word;
    always_ff @(posedge clock) begin
        if (load_en) begin
            regs[load_index] <= load_value;
        end else if (result_write) begin
            regs[result_index] <= result_value;
        end
    end
endmodule
`default_nettype wire

//--- verification/packed_simd_shift_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module packed_simd_shift_unit_tb;
    import pssu_pkg::*;
    logic clock, srst, issue_valid, source_is_memory, protected_mode, alignment_enabled;
    logic mem_misaligned, mem_addr_illegal, mem_stack_segment, mem_page_fault;
    logic emulation_control_bit, task_switched_bit, math_pending, load_en;
    logic [7:0] issue_escape, issue_opcode, issue_modrm, immediate_count_byte, fault_vector;
    logic [2:0] issue_dest_index, result_index, load_index;
    logic [1:0] current_privilege;
    logic [31:0] mem_last_offset;
    logic [63:0] dest_value, source_value, result_value, load_value, cnt;
    logic [63:0] mirror [8];
    logic result_write, fault_valid, flags_write;
    logic [15:0] fault_error_code;
    pssu_fault_type fault_kind;
    int fail_count = 0;
    int num_checks = 0;
    int t;
    // decode table: reg-count forms, then immediate forms by reg field
    logic [7:0] ops [16] = '{8'hf1, 8'hf2, 8'hf3, 8'he1, 8'he2, 8'hd1, 8'hd2, 8'hd3,
        8'h71, 8'h72, 8'h73, 8'h71, 8'h72, 8'h71, 8'h72, 8'h73};
    logic [2:0] rsel [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 6, 6, 6, 4, 4, 2, 2, 2};

    pssu_unit pssu_unit_i (.clock(clock), .srst(srst), .issue_valid(issue_valid),
        .issue_escape(issue_escape), .issue_opcode(issue_opcode), .issue_modrm(issue_modrm),
        .immediate_count_byte(immediate_count_byte), .issue_dest_index(issue_dest_index),
        .dest_value(dest_value), .source_value(source_value),
        .source_is_memory(source_is_memory), .protected_mode(protected_mode),
        .current_privilege(current_privilege), .alignment_enabled(alignment_enabled),
        .mem_misaligned(mem_misaligned), .mem_addr_illegal(mem_addr_illegal),
        .mem_stack_segment(mem_stack_segment), .mem_page_fault(mem_page_fault),
        .mem_last_offset(mem_last_offset), .emulation_control_bit(emulation_control_bit),
        .task_switched_bit(task_switched_bit), .math_pending(math_pending),
        .result_write(result_write), .result_index(result_index),
        .result_value(result_value), .fault_valid(fault_valid), .fault_kind(fault_kind),
        .fault_error_code(fault_error_code), .fault_vector(fault_vector),
        .flags_write(flags_write));
    pssu_regfile_model pssu_regfile_model_i (.clock(clock), .issue_valid(issue_valid),
        .issue_dest_index(issue_dest_index), .dest_value(dest_value),
        .result_write(result_write), .result_index(result_index),
        .result_value(result_value), .load_en(load_en), .load_index(load_index),
        .load_value(load_value));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // bit-by-bit reference; any count at or above the lane width saturates to w
    function automatic logic [63:0] model(input logic [7:0] op, input logic [2:0] r,
        input logic [63:0] d, input logic [63:0] c);
        int w, k, p, ci;
        logic [63:0] res;
        w = (op inside {8'hf1, 8'he1, 8'hd1, 8'h71}) ? 16 :
            (op inside {8'hf2, 8'he2, 8'hd2, 8'h72}) ? 32 : 64;
        k = (op inside {8'hf1, 8'hf2, 8'hf3} || r == 3'h6) ? 0 :
            (op inside {8'he1, 8'he2} || r == 3'h4) ? 1 : 2;
        ci = (c >= 64'(w)) ? w : int'(c[6:0]);
        for (int b = 0; b < 64; b++) begin
            p = b % w;
            if (k == 0) res[b] = (p >= ci) ? d[b - ci] : 1'b0;
            else res[b] = (p + ci < w) ? d[b + ci] : (k == 1 && d[b - p + w - 1]);
        end
        return res;
    endfunction

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // entered at a falling edge; leaves issue_valid high so calls run back to back
    task automatic issue(input logic [7:0] op, input logic [7:0] md, input logic [7:0] im,
        input logic [63:0] src, input pssu_fault_type ef);
        logic [63:0] e;
        logic [2:0] ix;
        ix = 3'($urandom);
        e = model(op, op[7:4] == 4'h7 ? md[5:3] : 3'h0, mirror[ix],
            op[7:4] == 4'h7 ? {56'h0, im} : src);
        issue_valid = 1'b1;
        issue_opcode = op;
        issue_modrm = md;
        immediate_count_byte = im;
        source_value = src;
        issue_dest_index = ix;
        @(posedge clock);
        @(negedge clock);
        chk(result_write, ef == PSSU_FAULT_NONE);
        chk(fault_valid, ef != PSSU_FAULT_NONE);
        chk(fault_kind, ef);
        chk(fault_vector, ef == PSSU_FAULT_REAL_INT13 ? 8'h0d : 8'h00);
        chk(fault_error_code, 16'h0000);
        chk(flags_write, 1'b0);
        if (ef == PSSU_FAULT_NONE) begin
            chk(result_value, e);
            chk(result_index, ix);
            mirror[ix] = e;
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {issue_valid, source_is_memory, alignment_enabled, mem_misaligned, load_en} = '0;
        {mem_addr_illegal, mem_stack_segment, mem_page_fault, math_pending} = '0;
        {emulation_control_bit, task_switched_bit, load_index, current_privilege} = '0;
        {issue_opcode, issue_modrm, immediate_count_byte, issue_dest_index} = '0;
        {source_value, load_value, mem_last_offset} = '0;
        issue_escape = 8'h0f;
        protected_mode = 1'b1;
        srst = 1'b1;
        void'($urandom(32'hc3926b1e));
        repeat (2) @(negedge clock);
        srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            load_en = 1'b1;
            load_index = 3'(i);
            load_value = {$urandom, $urandom};
            mirror[i] = load_value;
            @(negedge clock);
        end
        load_en = 1'b0;
        for (int i = 0; i < 80; i++) begin
            t = i % 16;
            // a large count whose low bits look small must still saturate
            cnt = (i % 5 == 4) ? {32'($urandom) | 32'h1, 32'h3} : 64'($urandom_range(0, 70));
            source_is_memory = 1'($urandom);
            issue(ops[t], {2'h3, rsel[t], 3'($urandom)}, 8'($urandom_range(0, 70)), cnt,
                PSSU_FAULT_NONE);
        end
        issue(8'h71, 8'he0, 8'hff, 64'h0, PSSU_FAULT_NONE);
        issue(8'hd3, 8'hc0, 8'h00, 64'h3f, PSSU_FAULT_NONE);
        issue(8'hf3, 8'hc0, 8'h00, 64'h40, PSSU_FAULT_NONE);
        emulation_control_bit = 1'b1;
        task_switched_bit = 1'b1;
        issue(8'hf1, 8'hc0, 8'h00, 64'h1, PSSU_FAULT_INVALID_OPCODE);
        emulation_control_bit = 1'b0;
        issue(8'hf1, 8'hc0, 8'h00, 64'h1, PSSU_FAULT_DEVICE_NOT_AVAILABLE);
        task_switched_bit = 1'b0;
        math_pending = 1'b1;
        issue(8'he2, 8'hc0, 8'h00, 64'h1, PSSU_FAULT_MATH);
        math_pending = 1'b0;
        issue_escape = 8'h0e;
        issue(8'hf1, 8'hc0, 8'h00, 64'h1, PSSU_FAULT_INVALID_OPCODE);
        issue_escape = 8'h0f;
        issue(8'h73, 8'he0, 8'h01, 64'h0, PSSU_FAULT_INVALID_OPCODE);
        issue(8'h71, 8'h30, 8'h01, 64'h0, PSSU_FAULT_INVALID_OPCODE);
        source_is_memory = 1'b1;
        mem_addr_illegal = 1'b1;
        // immediate forms have no memory count, so the address fault must not show
        issue(8'h72, 8'hd0, 8'h03, 64'h0, PSSU_FAULT_NONE);
        issue(8'hd2, 8'h06, 8'h00, 64'h2, PSSU_FAULT_GENERAL_PROTECTION);
        mem_stack_segment = 1'b1;
        issue(8'hd2, 8'h06, 8'h00, 64'h2, PSSU_FAULT_STACK);
        {mem_addr_illegal, mem_stack_segment, mem_page_fault} = 3'h1;
        issue(8'hd1, 8'h06, 8'h00, 64'h2, PSSU_FAULT_PAGE);
        {mem_page_fault, mem_misaligned, alignment_enabled} = 3'h3;
        current_privilege = 2'h3;
        issue(8'he1, 8'h06, 8'h00, 64'h2, PSSU_FAULT_ALIGNMENT_CHECK);
        current_privilege = 2'h2;
        issue(8'he1, 8'h06, 8'h00, 64'h2, PSSU_FAULT_NONE);
        protected_mode = 1'b0;
        mem_last_offset = 32'h00010000;
        issue(8'hf2, 8'h06, 8'h00, 64'h5, PSSU_FAULT_REAL_INT13);
        mem_last_offset = 32'h0000ffff;
        issue(8'hf2, 8'h06, 8'h00, 64'h5, PSSU_FAULT_NONE);
        issue_valid = 1'b0;
        @(posedge clock);
        @(negedge clock);
        chk({result_write, fault_valid}, 2'h0);
        srst = 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk({result_write, fault_valid}, 2'h0);
        chk(result_value, 64'h0);
        chk({result_index, fault_vector, fault_error_code}, 27'h0);
        chk(fault_kind, PSSU_FAULT_NONE);
        srst = 1'b0;
        @(negedge clock);
        // recovery after reset; a zero count must leave the lanes untouched
        issue(8'hd1, 8'hc0, 8'h00, 64'h0, PSSU_FAULT_NONE);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
